//--- bench/bdma_core_model.sv
// Purpose: Core-side model that issues data accesses and strobes.
// Assumes: Requests are driven just after the rising edge of sys_clk.
// Notes:   Released operand, address and write-data lines are inverted so a stale value cannot pass.
`timescale 1ns/1ps

module bdma_core_model
   import bdma_pkg::*;
(
   // Clock.
   input wire logic sys_clk,
   // Requests towards the memory block.
   output logic acc_valid,
   output bdma_mode_e acc_mode,
   output logic [7:0] acc_operand,
   output logic [11:0] acc_full_addr,
   output logic acc_write,
   output logic [7:0] acc_wdata,
   output logic load_bank_literal_instr,
   output logic [7:0] bank_literal,
   output logic flag_update,
   output logic [4:0] flag_value
);
   ////////////////////////////////////////////////////////////////
   // Quiet request lines from time zero.
   initial begin
      {acc_valid, acc_write, load_bank_literal_instr, flag_update} = 4'h0;
      acc_mode = BDMA_MODE_BANKED;
      {acc_operand, acc_full_addr, acc_wdata, bank_literal, flag_value} = 41'h0;
   end

   // One request for one cycle; the strobes drop at the edge that takes it.
   task automatic issue(input logic v, input bdma_mode_e m, input logic [7:0] op,
      input logic [11:0] fa, input logic wr, input logic [7:0] wd, input logic ld,
      input logic [7:0] lit, input logic fu, input logic [4:0] fv);
      @(posedge sys_clk);
      acc_valid <= v;
      acc_mode <= m;
      acc_operand <= op;
      acc_full_addr <= fa;
      acc_write <= wr;
      acc_wdata <= wd;
      load_bank_literal_instr <= ld;
      bank_literal <= lit;
      flag_update <= fu;
      flag_value <= fv;
      @(posedge sys_clk);
      {acc_valid, load_bank_literal_instr, flag_update} <= 3'h0;
      acc_operand <= ~op;
      acc_full_addr <= ~fa;
      acc_wdata <= ~wd;
   endtask
endmodule

//--- bench/testbench.sv
// Purpose: Self-checking bench for the banked data memory block.
// Assumes: A second instance with eight banks shows absent-bank behaviour.
// Notes:   Expected values come from a byte-wide reference image.
`timescale 1ns/1ps

module testbench;
   import bdma_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic acc_valid, acc_write, load_bank_literal_instr, flag_update;
   bdma_mode_e acc_mode;
   logic [7:0] acc_operand, acc_wdata, bank_literal, rd_data, sm_rd_data, pc_byte;
   logic [11:0] acc_full_addr, last_addr;
   logic [4:0] flag_value, status_flags, sm_flags;
   logic [3:0] bank_pointer, bp_exp;
   logic rd_valid, pc_wr;
   logic [7:0] ref_mem [0:4095];
   logic [7:0] pc_exp;
   logic [4:0] fl_exp;
   int err_total = 0;
   int tests_run = 0;
   int cycles = 0;

   ////////////////////////////////////////////////////////////////
   // Clock, core model and the two memory instances.
   always #4 sys_clk = ~sys_clk;
   bdma_core_model u_core (.sys_clk(sys_clk), .acc_valid(acc_valid), .acc_mode(acc_mode),
      .acc_operand(acc_operand), .acc_full_addr(acc_full_addr), .acc_write(acc_write),
      .acc_wdata(acc_wdata), .load_bank_literal_instr(load_bank_literal_instr),
      .bank_literal(bank_literal), .flag_update(flag_update), .flag_value(flag_value));
   bdma_top u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .acc_valid(acc_valid),
      .acc_mode(acc_mode), .acc_operand(acc_operand), .acc_full_addr(acc_full_addr),
      .acc_write(acc_write), .acc_wdata(acc_wdata), .rd_valid(rd_valid), .rd_data(rd_data),
      .last_addr(last_addr), .load_bank_literal_instr(load_bank_literal_instr),
      .bank_literal(bank_literal), .flag_update(flag_update), .flag_value(flag_value),
      .bank_pointer(bank_pointer), .status_flags(status_flags),
      .program_counter_low_byte_wr(pc_wr), .program_counter_low_byte(pc_byte));
   bdma_top #(.BANKS_IMPL(8)) u_dut_small (.sys_clk(sys_clk), .rst_n(rst_n),
      .acc_valid(acc_valid), .acc_mode(acc_mode), .acc_operand(acc_operand),
      .acc_full_addr(acc_full_addr), .acc_write(acc_write), .acc_wdata(acc_wdata),
      .rd_valid(), .rd_data(sm_rd_data), .last_addr(),
      .load_bank_literal_instr(load_bank_literal_instr), .bank_literal(bank_literal),
      .flag_update(flag_update), .flag_value(flag_value), .bank_pointer(),
      .status_flags(sm_flags), .program_counter_low_byte_wr(),
      .program_counter_low_byte());

   ////////////////////////////////////////////////////////////////
   // Address formation as the core expects it.
   function automatic logic [11:0] form(bdma_mode_e m, logic [7:0] op, logic [11:0] fa);
      if (m == BDMA_MODE_BANKED) return {bp_exp, op};
      if (m == BDMA_MODE_WINDOW) return (op < 8'h60) ? {4'h0, op} : {4'hF, op};
      return fa;
   endfunction

   // Read value; only three special registers exist, the rest read zero.
   function automatic logic [7:0] exp_rd(logic [11:0] a);
      if (a < 12'hF60) return ref_mem[a];
      if (a == 12'hFE0) return {4'h0, bp_exp};
      if (a == 12'hFD8) return {3'h0, fl_exp};
      if (a == 12'hFF9) return pc_exp;
      return 8'h00;
   endfunction

   task automatic chk(input string name, input logic [11:0] e, input logic [11:0] g);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", name, e, g);
      end
   endtask

   // One access, then its address, read answer, PC pulse and bank pointer are compared.
   task automatic acc(input bdma_mode_e m, input logic [7:0] op, input logic [11:0] fa,
      input logic wr, input logic [7:0] wd);
      logic [11:0] a;
      a = form(m, op, fa);
      u_core.issue(1'b1, m, op, fa, wr, wd, 1'b0, 8'h00, 1'b0, 5'h00);
      #1;
      chk("last_addr", a, last_addr);
      chk("pc_wr", {11'h0, wr && a == 12'hFF9}, {11'h0, pc_wr});
      if (wr) begin
         if (a < 12'hF60) ref_mem[a] = wd;
         if (a == 12'hFE0) bp_exp = wd[3:0];
         if (a == 12'hFD8) fl_exp = wd[4:0];
         if (a == 12'hFF9) pc_exp = wd;
      end else begin
         chk("rd_valid", 12'h1, {11'h0, rd_valid});
         chk("rd_data", {4'h0, exp_rd(a)}, {4'h0, rd_data});
         chk("small_rd", {4'h0, (a < 12'hF60 && a[11:8] >= 4'h8) ? 8'h00 : exp_rd(a)},
            {4'h0, sm_rd_data});
      end
      chk("bank_pointer", {8'h0, bp_exp}, {8'h0, bank_pointer});
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // A hang is cut short well past the expected run length.
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_total++;
         results();
      end
   end

   ////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      logic [7:0] lit, wd;
      logic [11:0] a, fa;
      bdma_mode_e m;
      void'($urandom(25757));
      {bp_exp, fl_exp, pc_exp} = 17'h0;
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      #1;
      chk("rst_bank", 12'h0, {8'h0, bank_pointer});
      chk("rst_flags", 12'h0, {7'h0, status_flags});
      $display("test reset done");
      // Every stored byte gets a known value first, so no later read compares unknowns.
      for (int j = 0; j < 3936; j++) begin
         acc(BDMA_MODE_FULL, 8'h00, 12'(j), 1'b1, 8'($urandom));
      end
      $display("test fill done");
      for (int i = 0; i < 200; i++) begin
         lit = 8'($urandom);
         u_core.issue(1'b0, BDMA_MODE_BANKED, 8'h00, 12'h000, 1'b0, 8'h00, 1'b1, lit,
            1'b0, 5'h00);
         bp_exp = lit[3:0];
         #1 chk("bank_load", {8'h0, lit[3:0]}, {8'h0, bank_pointer});
         m = bdma_mode_e'($urandom_range(3, 0));
         lit = 8'($urandom);
         fa = 12'($urandom);
         wd = 8'($urandom);
         a = form(m, lit, fa);
         acc(m, lit, fa, 1'b1, wd);
         acc(BDMA_MODE_FULL, 8'h00, a, 1'b0, 8'h00);
         acc(BDMA_MODE_WINDOW, a[7:0], 12'h000, 1'b0, 8'h00);
         acc(BDMA_MODE_BANKED, a[7:0], 12'h000, 1'b0, 8'h00);
      end
      $display("test random done");
      for (int k = 0; k < 4; k++) begin
         a = (k == 0) ? 12'hF60 : (k == 1) ? 12'hF7B : (k == 2) ? 12'hFD4 : 12'hFFF;
         acc(BDMA_MODE_POINTER, 8'h00, a, 1'b1, 8'hFF);
         acc(BDMA_MODE_FULL, 8'h00, a, 1'b0, 8'h00);
      end
      acc(BDMA_MODE_FULL, 8'h00, 12'hFE0, 1'b1, 8'hFF);
      acc(BDMA_MODE_FULL, 8'h00, 12'hFE0, 1'b0, 8'h00);
      acc(BDMA_MODE_WINDOW, 8'hE0, 12'h000, 1'b0, 8'h00);
      acc(BDMA_MODE_BANKED, 8'hF9, 12'h000, 1'b1, 8'h42);
      #0 chk("pc_byte", 12'h042, {4'h0, pc_byte});
      acc(BDMA_MODE_WINDOW, 8'hF9, 12'h000, 1'b0, 8'h00);
      acc(BDMA_MODE_FULL, 8'h00, 12'hFD8, 1'b1, 8'hEA);
      acc(BDMA_MODE_WINDOW, 8'hD8, 12'h000, 1'b0, 8'h00);
      $display("test special done");
      u_core.issue(1'b1, BDMA_MODE_FULL, 8'h00, 12'hA00, 1'b1, 8'h5A, 1'b0, 8'h00,
         1'b1, 5'h15);
      ref_mem[12'hA00] = 8'h5A;
      fl_exp = 5'h15;
      #1 chk("small_flags", 12'h015, {7'h0, sm_flags});
      chk("flags", {7'h0, fl_exp}, {7'h0, status_flags});
      acc(BDMA_MODE_FULL, 8'h00, 12'hA00, 1'b0, 8'h00);
      $display("test absent bank done");
      results();
   end
endmodule

//--- core/bdma_addr_gen.sv
// Purpose: Forms the 12-bit data address from an operand or a full address.
// Assumes: Purely combinational; the caller registers what it needs.
// Notes:   Pointer mode serves indirect and indexed access with a full address.
`timescale 1ns/1ps
`include "bdma_consts.svh"

module bdma_addr_gen
   import bdma_pkg::*;
(
   // Request from the core.
   input wire bdma_mode_e mode,
   input wire logic [7:0] operand,
   input wire logic [11:0] full_addr,
   input wire logic [3:0] bank_ptr,
   // Formed address.
   output logic [11:0] addr
);

   // Fast-access window mapping of an 8-bit operand.
   function automatic logic [11:0] window_map(input logic [7:0] op);
      if (op < `BDMA_WIN_SPLIT) begin
         window_map = {`BDMA_WIN_LOW_BANK, op};
      end else begin
         window_map = {`BDMA_WIN_HIGH_BANK, op};
      end
   endfunction

   // Select the source of the address for each mode.
   always_comb begin
      unique case (mode)
         // (RULE5) (RULE11) Banked address form.
         BDMA_MODE_BANKED: addr = {bank_ptr, operand};
         // (RULE4) (RULE15) Window split mapping.
         BDMA_MODE_WINDOW: addr = window_map(operand);
         // (RULE10) Full address, pointer ignored.
         BDMA_MODE_FULL: addr = full_addr;
         // (RULE14) Indirect and indexed access.
         BDMA_MODE_POINTER: addr = full_addr;
      endcase
   end

endmodule

//--- core/bdma_consts.svh
// Purpose: Address map and reset values for the banked data memory block.
// Assumes: 12-bit byte addresses, 8-bit data.
// Notes:   Definitions only.
`ifndef BDMA_CONSTS_SVH
`define BDMA_CONSTS_SVH

// Address geometry.
`define BDMA_ADDR_W 12
`define BDMA_DATA_W 8
`define BDMA_BANK_W 4
`define BDMA_BANK_BYTES 256
`define BDMA_NUM_BANKS 16

// Special function register area, top of the last bank.
`define BDMA_SFR_BASE 12'hF60
`define BDMA_SFR_TOP 12'hFFF
`define BDMA_BANK_PTR_ADDR 12'hFE0
`define BDMA_STATUS_ADDR 12'hFD8
`define BDMA_PC_LOW_ADDR 12'hFF9

// Fast-access window split point and the upper bank it reaches.
`define BDMA_WIN_SPLIT 8'h60
`define BDMA_WIN_LOW_BANK 4'h0
`define BDMA_WIN_HIGH_BANK 4'hF

// Field layout of the bank pointer and the flag register.
`define BDMA_BANK_PTR_MASK 8'h0F
`define BDMA_FLAG_W 5

// Reset values.
`define BDMA_BANK_PTR_RST 4'h0
`define BDMA_FLAG_RST 5'h00
`define BDMA_DATA_ZERO 8'h00

`endif

//--- core/bdma_gpr_ram.sv
// Purpose: General purpose byte storage below the special function area.
// Assumes: Write is synchronous, read is combinational.
// Notes:   Banks numbered BANKS_IMPL and up are absent; writes drop and reads give zero.
`timescale 1ns/1ps
`include "bdma_consts.svh"

module bdma_gpr_ram #(
   parameter int BANKS_IMPL = `BDMA_NUM_BANKS
) (
   // Clock input.
   input wire logic sys_clk,
   // Access port.
   input wire logic [11:0] addr,
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   output logic [7:0] rd_data,
   output logic hit
);

   localparam int DEPTH = `BDMA_SFR_BASE;

   // Elaboration check on the number of present banks.
   generate
      if (BANKS_IMPL < 1 || BANKS_IMPL > `BDMA_NUM_BANKS) begin : g_bad_banks
         $error("BANKS_IMPL must lie between 1 and 16");
      end
   endgenerate

   logic [7:0] mem [0:DEPTH-1];

   // (RULE2) (RULE8) Present-bank decode.
   assign hit = ({1'b0, addr[11:8]} < 5'(BANKS_IMPL)) && (addr < `BDMA_SFR_BASE);

   // (RULE1) Byte storage write.
   always_ff @(posedge sys_clk) begin
      if (wr_en && hit) begin
         mem[addr] <= wr_data;
      end
   end

   // (RULE3) Absent bytes read zero.
   assign rd_data = hit ? mem[addr] : `BDMA_DATA_ZERO;

endmodule

//--- core/bdma_pkg.sv
// Purpose: Types shared by the banked data memory block.
// Assumes: Constants come from bdma_consts.svh.
// Notes:   Only types live here.
package bdma_pkg;

   // How the core asks for an address to be formed.
   typedef enum logic [1:0] {
      BDMA_MODE_BANKED  = 2'h0,
      BDMA_MODE_WINDOW  = 2'h1,
      BDMA_MODE_FULL    = 2'h2,
      BDMA_MODE_POINTER = 2'h3
   } bdma_mode_e;

   typedef logic [11:0] bdma_addr_t;
   typedef logic [7:0] bdma_byte_t;

endpackage

//--- core/bdma_top.sv
// Purpose: Banked data memory and address formation for an 8-bit core.
// Assumes: Core requests are synchronous to sys_clk and one per cycle.
// Notes:   Read data appears one cycle after the request with rd_valid.
// Behaviour
// (RULE1) Twelve-bit byte address, 4096 byte space.
// (RULE2) Up to sixteen banks of 256 bytes; upper banks may be absent.
// (RULE3) Unimplemented locations read as zero.
// (RULE4) Fast window reaches SFRs and bank 0.
// (RULE5) Banked address: pointer high, operand low.
// (RULE6) Bank pointer bits 7:4 read zero.
// (RULE7) Load-bank-literal instruction loads bank pointer.
// (RULE8) Absent bank: writes dropped, reads zero.
// (RULE9) Flags update even for absent banks.
// (RULE10) Full-address move ignores the bank pointer.
// (RULE11) Other instructions use pointer or window.
// (RULE12) SFRs at F60h..FFFh, unused read zero.
// (RULE13) Banked F9h write in bank Fh hits PC.
// (RULE14) All banks reachable by indirect and indexed addressing.
// (RULE15) Window: 00h-5Fh bank 0, 60h-FFh F60h-FFFh.
`timescale 1ns/1ps
`include "bdma_consts.svh"

module bdma_top
   import bdma_pkg::*;
#(
   parameter int BANKS_IMPL = `BDMA_NUM_BANKS
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst_n,
   // Data access request from the core.
   input wire logic acc_valid,
   input wire bdma_mode_e acc_mode,
   input wire logic [7:0] acc_operand,
   input wire logic [11:0] acc_full_addr,
   input wire logic acc_write,
   input wire logic [7:0] acc_wdata,
   // Read answer.
   output logic rd_valid,
   output logic [7:0] rd_data,
   output logic [11:0] last_addr,
   // Load-bank-literal instruction.
   input wire logic load_bank_literal_instr,
   input wire logic [7:0] bank_literal,
   // Arithmetic flag update from the ALU.
   input wire logic flag_update,
   input wire logic [4:0] flag_value,
   // Core-facing state.
   output logic [3:0] bank_pointer,
   output logic [4:0] status_flags,
   output logic program_counter_low_byte_wr,
   output logic [7:0] program_counter_low_byte
);

   ////////////////////////////////////////////////////////////////////////////
   // Address formation and storage.

   logic [11:0] addr;
   logic [7:0] gpr_rdata;
   logic gpr_hit;
   logic wr_req;
   logic sfr_bank_ptr_hit;
   logic sfr_status_hit;
   logic sfr_pc_low_hit;
   logic [7:0] next_rd_data;

   // The pointer names at most sixteen banks, so a larger count could never be
   // reached, and a block with no storage at all is not worth building.
   generate
      if (BANKS_IMPL < 1 || BANKS_IMPL > `BDMA_NUM_BANKS) begin : g_bad_banks
         $error("BANKS_IMPL out of range for the bank pointer");
      end
   endgenerate

   // Every mode resolves through one address former.
   bdma_addr_gen u_addr_gen (
      .mode(acc_mode),
      .operand(acc_operand),
      .full_addr(acc_full_addr),
      .bank_ptr(bank_pointer),
      .addr(addr)
   );

   assign wr_req = acc_valid && acc_write;

   // General purpose storage; absent banks are handled inside.
   bdma_gpr_ram #(
      .BANKS_IMPL(BANKS_IMPL)
   ) u_gpr_ram (
      .sys_clk(sys_clk),
      .addr(addr),
      .wr_en(wr_req),
      .wr_data(acc_wdata),
      .rd_data(gpr_rdata),
      .hit(gpr_hit)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Special function register decode.

   // (RULE12) Implemented SPECIAL_FUNCTION_REGS decode.
   assign sfr_bank_ptr_hit = (addr == `BDMA_BANK_PTR_ADDR);
   assign sfr_status_hit = (addr == `BDMA_STATUS_ADDR);
   assign sfr_pc_low_hit = (addr == `BDMA_PC_LOW_ADDR);

   // Read mux; anything not decoded returns zero so peripherals can be added later.
   always_comb begin
      next_rd_data = `BDMA_DATA_ZERO;
      // (RULE6) Upper pointer bits zero.
      if (sfr_bank_ptr_hit) begin
         next_rd_data = {4'h0, bank_pointer};
      end else if (sfr_status_hit) begin
         next_rd_data = {3'h0, status_flags};
      end else if (sfr_pc_low_hit) begin
         next_rd_data = program_counter_low_byte;
      // (RULE3) Unimplemented reads as zero.
      end else if (gpr_hit) begin
         next_rd_data = gpr_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bank pointer.

   // A literal load wins over a data write in the same cycle, as the core
   // never issues both and the instruction is the more deliberate source.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         bank_pointer <= `BDMA_BANK_PTR_RST;
      // (RULE7) Literal bank load.
      end else if (load_bank_literal_instr) begin
         bank_pointer <= bank_literal[3:0];
      // (RULE6) Only low nibble written.
      end else if (wr_req && sfr_bank_ptr_hit) begin
         bank_pointer <= acc_wdata[3:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Arithmetic flags.

   // The ALU update wins over a data write so the result of the operation
   // itself is never lost.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         status_flags <= `BDMA_FLAG_RST;
      // (RULE9) Flags update regardless of target.
      end else if (flag_update) begin
         status_flags <= flag_value;
      end else if (wr_req && sfr_status_hit) begin
         status_flags <= acc_wdata[4:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Program counter low byte.

   // A write here redirects program flow, so the core sees a one-cycle pulse.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         program_counter_low_byte <= `BDMA_DATA_ZERO;
         program_counter_low_byte_wr <= 1'b0;
      end else begin
         // (RULE13) PC low byte write.
         program_counter_low_byte_wr <= wr_req && sfr_pc_low_hit;
         if (wr_req && sfr_pc_low_hit) begin
            program_counter_low_byte <= acc_wdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read answer.

   // Registered answer, one cycle after the request.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_valid <= 1'b0;
         rd_data <= `BDMA_DATA_ZERO;
         last_addr <= 12'h000;
      end else begin
         rd_valid <= acc_valid && !acc_write;
         if (acc_valid) begin
            last_addr <= addr;
         end
         if (acc_valid && !acc_write) begin
            rd_data <= next_rd_data;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   banked_addr_form_a: assert property ( // RULE5
      @(posedge sys_clk) disable iff (!rst_n)
      acc_valid && acc_mode == BDMA_MODE_BANKED |=>
         last_addr == {$past(bank_pointer), $past(acc_operand)})
      else $error("banked address not pointer and operand");

   window_map_a: assert property ( // RULE15
      @(posedge sys_clk) disable iff (!rst_n)
      acc_valid && acc_mode == BDMA_MODE_WINDOW |=>
         last_addr == ($past(acc_operand) < 8'h60 ? {4'h0, $past(acc_operand)}
                                                  : {4'hF, $past(acc_operand)}))
      else $error("window mapping wrong");

   full_addr_a: assert property ( // RULE10
      @(posedge sys_clk) disable iff (!rst_n)
      acc_valid && acc_mode == BDMA_MODE_FULL |=> last_addr == $past(acc_full_addr))
      else $error("full address move used the bank pointer");

   literal_load_a: assert property ( // RULE7
      @(posedge sys_clk) disable iff (!rst_n)
      load_bank_literal_instr |=> bank_pointer == $past(bank_literal[3:0]))
      else $error("literal load of bank pointer failed");

   bank_ptr_read_a: assert property ( // RULE6
      @(posedge sys_clk) disable iff (!rst_n)
      acc_valid && !acc_write && sfr_bank_ptr_hit |=>
         rd_valid && rd_data[7:4] == 4'h0 && rd_data[3:0] == $past(bank_pointer))
      else $error("bank pointer readback wrong");

   absent_read_zero_a: assert property ( // RULE3
      @(posedge sys_clk) disable iff (!rst_n)
      acc_valid && !acc_write && !gpr_hit && !sfr_bank_ptr_hit && !sfr_status_hit
         && !sfr_pc_low_hit |=> rd_valid && rd_data == 8'h00)
      else $error("unimplemented location read nonzero");

   flag_update_a: assert property ( // RULE9
      @(posedge sys_clk) disable iff (!rst_n)
      flag_update |=> status_flags == $past(flag_value))
      else $error("flags not updated");

   pc_low_write_a: assert property ( // RULE13
      @(posedge sys_clk) disable iff (!rst_n)
      acc_valid && acc_write && acc_mode == BDMA_MODE_BANKED && acc_operand == 8'hF9
         && bank_pointer == 4'hF |=>
         program_counter_low_byte_wr && program_counter_low_byte == $past(acc_wdata))
      else $error("banked write to F9h in bank Fh missed PC low byte");

   // The core leaves one idle cycle between accesses, so the read-back is
   // checked across that gap; the storage itself has no such limit.
   write_readback_a: assert property ( // RULE1
      @(posedge sys_clk) disable iff (!rst_n)
      acc_valid && acc_write && gpr_hit ##1 !acc_valid ##1
         acc_valid && !acc_write && addr == $past(addr, 2) |=>
         rd_data == $past(acc_wdata, 3))
      else $error("stored byte not read back");

   // Absent storage, the pointer-mode path and operand placement.
   absent_bank_read_a: assert property ( // RULE8
      @(posedge sys_clk) disable iff (!rst_n)
      acc_valid && !acc_write && !gpr_hit && addr < 12'hF60 |=>
         rd_valid && rd_data == 8'h00)
      else $error("read of an absent bank not zero");

   pointer_addr_a: assert property ( // RULE14
      @(posedge sys_clk) disable iff (!rst_n)
      acc_valid && acc_mode == BDMA_MODE_POINTER |=> last_addr == $past(acc_full_addr))
      else $error("pointer access did not use the full address");

   operand_low_a: assert property ( // RULE11
      @(posedge sys_clk) disable iff (!rst_n)
      acc_valid && (acc_mode == BDMA_MODE_BANKED || acc_mode == BDMA_MODE_WINDOW) |=>
         last_addr[7:0] == $past(acc_operand))
      else $error("operand did not form the low address byte");

   // Special register answers; the window must reach them in a single cycle
   // whatever the pointer holds.
   window_special_a: assert property ( // RULE4
      @(posedge sys_clk) disable iff (!rst_n)
      acc_valid && !acc_write && acc_mode == BDMA_MODE_WINDOW && acc_operand == 8'hE0 |=>
         rd_valid && rd_data == {4'h0, $past(bank_pointer)})
      else $error("window read of the bank pointer wrong");

   bank_ptr_write_a: assert property ( // RULE6
      @(posedge sys_clk) disable iff (!rst_n)
      acc_valid && acc_write && sfr_bank_ptr_hit && !load_bank_literal_instr |=>
         bank_pointer == $past(acc_wdata[3:0]))
      else $error("bank pointer data write wrong");

   status_write_a: assert property ( // RULE12
      @(posedge sys_clk) disable iff (!rst_n)
      acc_valid && acc_write && sfr_status_hit && !flag_update |=>
         status_flags == $past(acc_wdata[4:0]))
      else $error("flag register data write wrong");

   status_read_a: assert property ( // RULE12
      @(posedge sys_clk) disable iff (!rst_n)
      acc_valid && !acc_write && sfr_status_hit |=> rd_data == {3'h0, $past(status_flags)})
      else $error("flag register readback wrong");

   pc_read_a: assert property ( // RULE12
      @(posedge sys_clk) disable iff (!rst_n)
      acc_valid && !acc_write && sfr_pc_low_hit |=> rd_data == $past(program_counter_low_byte))
      else $error("program counter low byte readback wrong");

   // The redirect pulse must never appear without a write that caused it.
   pc_pulse_a: assert property ( // RULE13
      @(posedge sys_clk) disable iff (!rst_n)
      program_counter_low_byte_wr |-> $past(acc_valid && acc_write && sfr_pc_low_hit))
      else $error("program counter write pulse without a write");

endmodule
